/* File: rtl/tmd_decoder.v */
// instruction decoder for the tuner controller io, port and clock instructions
// Function
// - lock-loss flag test, skip if clear
// - synthesizer load from data memory
// - internal register into data memory
// - data memory into internal register
// - load port control word
// - port read into data memory
// - data memory drives port
// - port bit set, clear, and tests
// - halt register load and clock stop in the same cycle
// - oscillator stop only when hold low
// - clear selected status register bits
`include "tmd_consts.vh"
module tmd_decoder
(
    input wire sys_clk_i,
    input wire resetn_i,
    input wire ce_i,
    input wire instr_valid_i,
    input wire [15:0] instr_i,
    input wire [3:0] lock_loss_i,
    input wire hold_i,
    input wire [3:0] port_pins_i,
    input wire [3:0] reg_rdata_i,
    input wire [3:0] mem_rdata_i,
    output reg [5:0] mem_addr_o,
    output reg mem_we_o,
    output reg [3:0] mem_wdata_o,
    output reg [3:0] reg_sel_o,
    output reg reg_we_o,
    output reg [3:0] reg_wdata_o,
    output reg reg_rd_o,
    output reg synth_we_o,
    output reg [3:0] synth_sel_o,
    output reg [3:0] synth_data_o,
    output reg [3:0] port_sel_o,
    output reg [3:0] port_out_o,
    output reg port_out_we_o,
    output reg port_dir_we_o,
    output reg [3:0] port_dir_o,
    output reg [3:0] halt_ctrl_o,
    output reg cpu_clk_stop_o,
    output reg osc_stop_o,
    output reg status_clr_o,
    output reg status_reg_sel_o,
    output reg [3:0] status_mask_o,
    output reg skip_o
);
    // pipeline states: decode, then finish operations needing a second cycle (memory, register and pin reads)
    localparam ST_DEC = 1'b0;
    localparam ST_FIN = 1'b1;

    reg state_q;
    reg [2:0] pend_q;
    reg [3:0] sel_q;
    reg [3:0] mask_q;
    reg skip_pend_q;
    reg hold_m_q;
    reg hold_s_q;
    reg [3:0] pin_m_q;
    reg [3:0] pin_s_q;
    reg [3:0] lock_m_q;
    reg [3:0] lock_s_q;
    reg pmem_we;
    reg [3:0] pmem_waddr;
    reg [3:0] pmem_wdata;
    wire [3:0] pmem_rdata;

    localparam PD_PLL = 3'h0;
    localparam PD_ROUT = 3'h1;
    localparam PD_OUT = 3'h2;
    localparam PD_TONE = 3'h3;
    localparam PD_TZERO = 3'h4;
    localparam PD_RIN = 3'h5;
    localparam PD_IN = 3'h6;

    wire [5:0] op6 = instr_i[15:10];
    wire [1:0] sub2 = instr_i[9:8];
    wire [7:0] hi8 = instr_i[15:8];
    wire [3:0] nib1 = instr_i[7:4];
    wire [3:0] nib0 = instr_i[3:0];

    // masked all-ones / all-zeros test used by port tests and lock flags
    function all_set;
        input [3:0] val;
        input [3:0] mask;
        begin
            all_set = ((val & mask) == mask);
        end
    endfunction

    function all_clr;
        input [3:0] val;
        input [3:0] mask;
        begin
            all_clr = ((val & mask) == 4'h0);
        end
    endfunction

    // pins, hold and lock flags come from outside the clock domain
    always @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            hold_m_q <= 1'b0;
            hold_s_q <= 1'b0;
            pin_m_q <= 4'h0;
            pin_s_q <= 4'h0;
            lock_m_q <= 4'h0;
            lock_s_q <= 4'h0;
        end
        else if (ce_i)
        begin
            hold_m_q <= hold_i;
            hold_s_q <= hold_m_q;
            pin_m_q <= port_pins_i;
            pin_s_q <= pin_m_q;
            lock_m_q <= lock_loss_i;
            lock_s_q <= lock_m_q;
        end
    end

    // port latch store; set and clear are read-modify-write via its registered read data pmem_rdata
    tmd_port_mem u_pmem
    (
        .sys_clk_i(sys_clk_i),
        .ce_i(ce_i),
        .we_i(pmem_we),
        .waddr_i(pmem_waddr),
        .wdata_i(pmem_wdata),
        .raddr_i(instr_i[7:4]),
        .rdata_o(pmem_rdata)
    );

    // set or clear modify the stored latch of the chosen port
    always @*
    begin
        pmem_we = 1'b0;
        pmem_wdata = 4'h0;
        pmem_waddr = nib1;
        // port output also refreshes the latch, so later set/clear see it
        if (ce_i && resetn_i && state_q == ST_FIN && pend_q == PD_OUT)
        begin
            pmem_we = 1'b1;
            pmem_wdata = mem_rdata_i;
            pmem_waddr = sel_q;
        end
        else if (ce_i && resetn_i && state_q == ST_DEC && instr_valid_i && !skip_pend_q)
        begin
            if (op6 == `TMD_HI_ZERO6 && sub2 == `TMD_SUB_BIT_SET)
            begin
                pmem_we = 1'b1;
                pmem_wdata = pmem_rdata | nib0;
            end
            else if (op6 == `TMD_HI_ZERO6 && sub2 == `TMD_SUB_BIT_CLR)
            begin
                pmem_we = 1'b1;
                pmem_wdata = pmem_rdata & ~nib0;
            end
        end
    end

    // main decode: one word per valid cycle, memory reads finish one cycle later
    always @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            state_q <= ST_DEC;
            pend_q <= PD_PLL;
            sel_q <= 4'h0;
            mask_q <= 4'h0;
            skip_pend_q <= 1'b0;
            mem_addr_o <= 6'h00;
            mem_we_o <= 1'b0;
            mem_wdata_o <= 4'h0;
            reg_sel_o <= 4'h0;
            reg_we_o <= 1'b0;
            reg_wdata_o <= 4'h0;
            reg_rd_o <= 1'b0;
            synth_we_o <= 1'b0;
            synth_sel_o <= 4'h0;
            synth_data_o <= 4'h0;
            port_sel_o <= 4'h0;
            port_out_o <= 4'h0;
            port_out_we_o <= 1'b0;
            port_dir_we_o <= 1'b0;
            port_dir_o <= 4'h0;
            halt_ctrl_o <= 4'h0;
            cpu_clk_stop_o <= 1'b0;
            osc_stop_o <= 1'b0;
            status_clr_o <= 1'b0;
            status_reg_sel_o <= 1'b0;
            status_mask_o <= 4'h0;
            skip_o <= 1'b0;
        end
        else if (ce_i)
        begin
            // strobes are single-cycle by default
            mem_we_o <= 1'b0;
            reg_we_o <= 1'b0;
            reg_rd_o <= 1'b0;
            synth_we_o <= 1'b0;
            port_out_we_o <= 1'b0;
            port_dir_we_o <= 1'b0;
            status_clr_o <= 1'b0;
            skip_o <= 1'b0;
            case (state_q)
                ST_DEC:
                begin
                    if (instr_valid_i && skip_pend_q)
                    begin
                        skip_pend_q <= 1'b0;
                    end
                    else if (instr_valid_i)
                    begin
                        mem_addr_o <= instr_i[9:4];
                        sel_q <= nib0;
                        mask_q <= nib0;
                        if (op6 == `TMD_OP_PLL)
                        begin
                            pend_q <= PD_PLL;
                            state_q <= ST_FIN;
                        end
                        else if (op6 == `TMD_OP_REG_IN)
                        begin
                            reg_sel_o <= nib0;
                            reg_rd_o <= 1'b1;
                            pend_q <= PD_RIN;
                            state_q <= ST_FIN;
                        end
                        else if (op6 == `TMD_OP_REG_OUT)
                        begin
                            pend_q <= PD_ROUT;
                            state_q <= ST_FIN;
                        end
                        else if (op6 == `TMD_OP_IN)
                        begin
                            port_sel_o <= nib0;
                            pend_q <= PD_IN;
                            state_q <= ST_FIN;
                        end
                        else if (op6 == `TMD_OP_OUT)
                        begin
                            pend_q <= PD_OUT;
                            state_q <= ST_FIN;
                        end
                        else if (hi8 == `TMD_HI_ONE8 && instr_i[7:5] == `TMD_STAT_CLR_CODE)
                        begin
                            status_clr_o <= 1'b1;
                            status_reg_sel_o <= instr_i[4];
                            status_mask_o <= nib0;
                        end
                        else if (op6 == `TMD_HI_ONE6 && sub2 == `TMD_SUB_DIR)
                        begin
                            port_dir_we_o <= 1'b1;
                            port_sel_o <= nib1;
                            port_dir_o <= nib0;
                        end
                        // port tests read pins next cycle
                        else if (op6 == `TMD_HI_ONE6 && sub2 == `TMD_SUB_TEST_ONE)
                        begin
                            port_sel_o <= nib1;
                            pend_q <= PD_TONE;
                            state_q <= ST_FIN;
                        end
                        else if (op6 == `TMD_HI_ONE6 && sub2 == `TMD_SUB_TEST_ZERO)
                        begin
                            port_sel_o <= nib1;
                            pend_q <= PD_TZERO;
                            state_q <= ST_FIN;
                        end
                        else if (op6 == `TMD_HI_ZERO6 && sub2 == `TMD_SUB_BIT_SET)
                        begin
                            port_sel_o <= nib1;
                            port_out_o <= pmem_rdata | nib0;
                            port_out_we_o <= 1'b1;
                        end
                        else if (op6 == `TMD_HI_ZERO6 && sub2 == `TMD_SUB_BIT_CLR)
                        begin
                            port_sel_o <= nib1;
                            port_out_o <= pmem_rdata & ~nib0;
                            port_out_we_o <= 1'b1;
                        end
                        else if (hi8 == `TMD_HI_ZERO8 && nib1 == `TMD_NIB_LOCKT)
                        begin
                            if (all_clr(lock_s_q, nib0))
                            begin
                                skip_o <= 1'b1;
                                skip_pend_q <= 1'b1;
                            end
                        end
                        else if (hi8 == `TMD_HI_ZERO8 && nib1 == `TMD_NIB_HALT)
                        begin
                            halt_ctrl_o <= nib0;
                            cpu_clk_stop_o <= 1'b1;
                        end
                        else if (hi8 == `TMD_HI_ZERO8 && nib1 == `TMD_NIB_OSC_STOP)
                        begin
                            if (!hold_s_q)
                                osc_stop_o <= 1'b1;
                        end
                    end
                end
                ST_FIN:
                begin
                    state_q <= ST_DEC;
                    case (pend_q)
                        PD_PLL:
                        begin
                            synth_we_o <= 1'b1;
                            synth_sel_o <= sel_q;
                            synth_data_o <= mem_rdata_i;
                        end
                        PD_ROUT:
                        begin
                            reg_we_o <= 1'b1;
                            reg_sel_o <= sel_q;
                            reg_wdata_o <= mem_rdata_i;
                        end
                        PD_OUT:
                        begin
                            port_out_we_o <= 1'b1;
                            port_sel_o <= sel_q;
                            port_out_o <= mem_rdata_i;
                        end
                        PD_RIN:
                        begin
                            mem_we_o <= 1'b1;
                            mem_wdata_o <= reg_rdata_i;
                        end
                        PD_IN:
                        begin
                            mem_we_o <= 1'b1;
                            mem_wdata_o <= pin_s_q;
                        end
                        PD_TONE:
                        begin
                            if (all_set(pin_s_q, mask_q))
                            begin
                                skip_o <= 1'b1;
                                skip_pend_q <= 1'b1;
                            end
                        end
                        PD_TZERO:
                        begin
                            if (all_clr(pin_s_q, mask_q))
                            begin
                                skip_o <= 1'b1;
                                skip_pend_q <= 1'b1;
                            end
                        end
                        default:
                        begin
                            state_q <= ST_DEC;
                        end
                    endcase
                end
                default:
                begin
                    state_q <= ST_DEC;
                end
            endcase
        end
    end
endmodule

/* File: inc/tmd_consts.vh */
// opcode fields, selectors and widths for the tuner io instruction decoder
`ifndef TMD_CONSTS_VH
`define TMD_CONSTS_VH
`define TMD_OP_PLL 6'h3e
`define TMD_OP_REG_IN 6'h0e
`define TMD_OP_REG_OUT 6'h0f
`define TMD_OP_IN 6'h3a
`define TMD_OP_OUT 6'h3b
`define TMD_HI_ZERO6 6'h00
`define TMD_HI_ONE6 6'h3f
`define TMD_SUB_TEST_ONE 2'h0
`define TMD_SUB_TEST_ZERO 2'h1
`define TMD_SUB_DIR 2'h2
`define TMD_SUB_BIT_SET 2'h2
`define TMD_SUB_BIT_CLR 2'h3
`define TMD_HI_ZERO8 8'h00
`define TMD_HI_ONE8 8'hff
`define TMD_NIB_LOCKT 4'hd
`define TMD_NIB_HALT 4'h4
`define TMD_NIB_OSC_STOP 4'h5
`define TMD_STAT_CLR_CODE 3'h1
`define TMD_PORTS 16
`define TMD_NOP 16'h0000
`endif

/* File: rtl/tmd_port_mem.v */
// sixteen-entry nibble store for port latches with registered read data
module tmd_port_mem
(
    input wire sys_clk_i,
    input wire ce_i,
    input wire we_i,
    input wire [3:0] waddr_i,
    input wire [3:0] wdata_i,
    input wire [3:0] raddr_i,
    output reg [3:0] rdata_o
);
    reg [3:0] mem_q [0:15];

    // write and registered read; contents hold across reset like a latch array
    always @(posedge sys_clk_i)
    begin
        if (ce_i)
        begin
            if (we_i)
                mem_q[waddr_i] <= wdata_i;
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule

/* File: dv/tmd_decoder_chk.sv */
// concurrent checks on the io instruction decoder ports
module tmd_decoder_chk
(
    input wire sys_clk_i,
    input wire resetn_i,
    input wire instr_valid_i,
    input wire [15:0] instr_i,
    input wire hold_i,
    input wire [3:0] reg_rdata_i,
    input wire [3:0] mem_rdata_i,
    input wire [5:0] mem_addr_o,
    input wire mem_we_o,
    input wire [3:0] mem_wdata_o,
    input wire [3:0] reg_sel_o,
    input wire reg_we_o,
    input wire [3:0] reg_wdata_o,
    input wire synth_we_o,
    input wire [3:0] synth_sel_o,
    input wire [3:0] synth_data_o,
    input wire [3:0] port_sel_o,
    input wire [3:0] port_out_o,
    input wire port_out_we_o,
    input wire port_dir_we_o,
    input wire [3:0] port_dir_o,
    input wire [3:0] halt_ctrl_o,
    input wire cpu_clk_stop_o,
    input wire osc_stop_o,
    input wire status_clr_o,
    input wire status_reg_sel_o,
    input wire [3:0] status_mask_o,
    input wire skip_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    // memory class strobes land two cycles after the word is taken
    a_synth_source: assert property (synth_we_o |-> $past(instr_i[15:10], 3) == 6'h3e
        && synth_data_o == $past(mem_rdata_i) && synth_sel_o == $past(instr_i[3:0], 3))
        else $error("synth load data or select wrong");
    a_mem_address: assert property (mem_we_o |-> mem_addr_o == $past(instr_i[9:4], 3))
        else $error("data memory write address wrong");
    a_regin_data: assert property (mem_we_o && $past(instr_i[15:10], 3) == 6'h0e
        |-> mem_wdata_o == $past(reg_rdata_i)) else $error("register input data wrong");
    a_regout_data: assert property (reg_we_o |-> reg_wdata_o == $past(mem_rdata_i)
        && reg_sel_o == $past(instr_i[3:0], 3)) else $error("register output wrong");
    a_port_out: assert property (port_out_we_o && $past(instr_i[15:10], 3) == 6'h3b
        |-> port_out_o == $past(mem_rdata_i) && port_sel_o == $past(instr_i[3:0], 3))
        else $error("port output wrong");
    // single-cycle ops answer one cycle after the word
    a_dir_load: assert property (port_dir_we_o |-> $past(instr_i[15:8], 2) == 8'hfe
        && port_dir_o == $past(instr_i[3:0], 2)) else $error("port control load wrong");
    a_status_clear: assert property (status_clr_o |-> $past(instr_i[15:5], 2) == 11'h7f9
        && status_mask_o == $past(instr_i[3:0], 2) && status_reg_sel_o == $past(instr_i[4], 2))
        else $error("status clear wrong");
    a_halt_stop: assert property ($rose(cpu_clk_stop_o) |-> $past(instr_valid_i)
        && $past(instr_i, 2) == {12'h004, halt_ctrl_o}) else $error("halt stop wrong");
    // hold passes a two-flop synchroniser before the decision
    a_osc_hold: assert property ($rose(osc_stop_o) |-> $past(instr_i, 2) == 16'h0050
        && !$past(hold_i, 3)) else $error("oscillator stop wrong");
    a_stop_sticky: assert property (cpu_clk_stop_o |=> cpu_clk_stop_o)
        else $error("clock stop released");
    a_skip_cause: assert property (skip_o |-> $past(instr_i[15:9], 3) == 7'h7e
        || $past(instr_i[15:4], 2) == 12'h00d) else $error("skip without test");
    a_skip_single: assert property (skip_o |=> !skip_o)
        else $error("skip longer than a pulse");

    c_skip: cover property (skip_o);
    c_synth: cover property (synth_we_o);
    c_osc: cover property ($rose(osc_stop_o));
    c_status: cover property (status_clr_o);
endmodule

/* File: dv/tmd_prog_model.sv */
// program memory model handing instruction words to the decoder
module tmd_prog_model
(
    input wire logic sys_clk_i,
    output logic instr_valid_o,
    output logic [15:0] instr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        instr_valid_o = 1'b0;
        instr_o = 16'h5a5a;
    end
    // word set up a cycle early, since port latch reads look ahead
    task automatic issue(input logic [15:0] w);
        instr_o <= w;
        @(posedge sys_clk_i);
        instr_valid_o <= 1'b1;
        @(posedge sys_clk_i);
        instr_valid_o <= 1'b0;
        // an idle bus never shows a stale copy of the word
        instr_o <= ~w;
    endtask
endmodule

/* File: dv/tmd_decoder_tb_top.sv */
// self-checking bench for the tuner io instruction decoder
module tmd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 0, resetn_i = 0, ce_i = 1, hold_i = 1, clr = 1;
    logic instr_valid_i;
    logic [15:0] instr_i, got_g;
    logic [3:0] lock_loss_i = 0, port_pins_i = 0, reg_rdata_i, mem_rdata_i;
    logic [5:0] mem_addr_o;
    logic [3:0] mem_wdata_o, reg_sel_o, reg_wdata_o, synth_sel_o, synth_data_o, port_sel_o;
    logic [3:0] port_out_o, port_dir_o, halt_ctrl_o, status_mask_o, got_v, got_s;
    logic mem_we_o, reg_we_o, reg_rd_o, synth_we_o, port_out_we_o, port_dir_we_o;
    logic cpu_clk_stop_o, osc_stop_o, status_clr_o, status_reg_sel_o, skip_o;
    logic [6:0] got_k;
    int failures = 0, compares = 0, cyc = 0, sk = 0;
    int dmem [64], regs [16], latch [16];

    tmd_decoder dut_u (.*);
    tmd_prog_model pm_u (.sys_clk_i, .instr_valid_o(instr_valid_i), .instr_o(instr_i));
    // data memory and register file answer combinationally
    assign mem_rdata_i = dmem[mem_addr_o][3:0];
    assign reg_rdata_i = regs[reg_sel_o][3:0];
    assign got_g = {1'b0, got_k, got_v, got_s};

    initial
    begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    // gather every strobe but reg_rd_o, and its data, between two clears
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            failures++;
            results();
        end
        got_k <= clr ? 7'h0 : got_k | {skip_o, status_clr_o, port_dir_we_o, port_out_we_o,
            synth_we_o, reg_we_o, mem_we_o};
        got_v <= clr ? 4'h0 : got_v | {4{mem_we_o}} & mem_wdata_o | {4{reg_we_o}} & reg_wdata_o
            | {4{synth_we_o}} & synth_data_o | {4{port_out_we_o}} & port_out_o
            | {4{port_dir_we_o}} & port_dir_o | {4{status_clr_o}} & status_mask_o;
        got_s <= clr ? 4'h0 : got_s | {4{mem_we_o}} & mem_addr_o[3:0] | {4{reg_we_o}} & reg_sel_o
            | {4{synth_we_o}} & synth_sel_o | {4{port_out_we_o}} & port_sel_o
            | {4{status_clr_o}} & {3'h0, status_reg_sel_o};
    end

    task automatic chk(input logic [15:0] a, input logic [15:0] b);
        compares++;
        if (a !== b)
        begin
            failures++;
            $display("mismatch t=%0t got %h exp %h", $time, a, b);
        end
    endtask

    // reference model: expected strobe kind, value and select of one word
    task automatic t(input logic [15:0] w);
        logic [6:0] k;
        int v, s, m, p;
        k = 0; v = 0; s = 0; m = w[3:0]; p = w[7:4];
        if (sk)
            sk = 0;
        else
            casez (w[15:8])
                8'b111110??: begin k = 7'h04; v = dmem[w[9:4]]; s = m; end
                8'b001110??: begin k = 7'h01; v = regs[m]; s = p; end
                8'b001111??: begin k = 7'h02; v = dmem[w[9:4]]; s = m; end
                8'b111010??: begin k = 7'h01; v = port_pins_i; s = p; end
                8'b111011??: begin k = 7'h08; v = dmem[w[9:4]]; s = m; latch[m] = v; end
                8'hfe: begin k = 7'h10; v = m; end
                8'h02: begin k = 7'h08; v = latch[p] | m; s = p; latch[p] = v; end
                8'h03: begin k = 7'h08; v = latch[p] & ~m; s = p; latch[p] = v; end
                8'hfc: k = ((port_pins_i & m) == m) ? 7'h40 : 7'h0;
                8'hfd: k = ((port_pins_i & m) == 0) ? 7'h40 : 7'h0;
                8'hff: if (w[7:5] == 3'h1) begin k = 7'h20; v = m; s = w[4]; end
                8'h00: if (p == 13 && (lock_loss_i & m) == 0) k = 7'h40;
                default: k = 7'h0;
            endcase
        sk = k[6];
        clr <= 1'b1;
        @(posedge sys_clk_i);
        clr <= 1'b0;
        pm_u.issue(w);
        repeat (4) @(posedge sys_clk_i);
        chk(got_g, {1'b0, k, v[3:0], s[3:0]});
    endtask

    task automatic results();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'hddeb));
        foreach (dmem[i]) dmem[i] = $urandom % 16;
        foreach (regs[i]) regs[i] = $urandom % 16;
        repeat (5) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        t(16'h0000);
        t(16'h0075);
        t(16'h0050);
        chk({15'h0, osc_stop_o}, 16'h0);
        for (int i = 0; i < 8; i++)
        begin
            port_pins_i <= $urandom;
            lock_loss_i <= $urandom;
            repeat (3) @(posedge sys_clk_i);
            t({6'h3e, 10'($urandom)});
            t({6'h0e, 10'($urandom)});
            t({6'h0f, 10'($urandom)});
            t({6'h3a, 10'($urandom)});
            t({8'hfe, 8'($urandom)});
            t({11'h7f9, 5'($urandom)});
            t({6'h3b, 6'($urandom), 4'(i)});
            t({8'h02, 4'(i), 4'($urandom)});
            t({8'h03, 4'(i), 4'($urandom)});
            t({7'h7e, 1'(i), 4'(i), 4'($urandom)});
            t({6'h3b, 10'($urandom)});
            t({12'h00d, 4'($urandom)});
            t({8'hfe, 8'($urandom)});
        end
        hold_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        t(16'h0050);
        chk({15'h0, osc_stop_o}, 16'h1);
        t(16'h004a);
        chk({11'h0, halt_ctrl_o, cpu_clk_stop_o}, 16'h0015);
        results();
    end

endmodule

bind tmd_decoder tmd_decoder_chk chk_u (.*);
